// ===== bsc_pkg.sv
// Shared constants for the boundary-scan pin chain.
package bsc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction register.
  localparam int unsigned IR_W                = 4;
  localparam logic [3:0]  OP_EXTEST           = 4'h0;
  localparam logic [3:0]  OP_IDCODE           = 4'h1;
  localparam logic [3:0]  OP_SAMPLE           = 4'h2;
  localparam logic [3:0]  OP_TEST_RESET_INSTR = 4'hC;
  localparam logic [3:0]  OP_BYPASS           = 4'hF;
  localparam logic [3:0]  IR_CAPTURE_VAL      = 4'h1;

  //////////////////////////////////////////////////////////////////////////////
  // Register map and fields.
  localparam logic [7:0]  ADDR_MCU_CONTROL      = 8'h35;
  localparam logic [7:0]  ADDR_MCU_RESET_STATUS = 8'h34;
  localparam int unsigned BIT_IFACE_DISABLE     = 7;
  localparam int unsigned BIT_PULLUP_OFF        = 4;
  localparam int unsigned BIT_SCAN_RESET_FLAG   = 4;
  localparam logic [7:0]  CTRL_PLAIN_MASK       = 8'h03;
  localparam logic [7:0]  RESET_VAL_8           = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Timed write window for the interface-disable bit, in clock cycles.
  localparam logic [2:0]  DISABLE_WINDOW = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // Chain layout: top position of the full-size chain, kept for reference.
  localparam int unsigned FULL_CHAIN_TOP = 164;

  //////////////////////////////////////////////////////////////////////////////
  // Controller modes.
  typedef enum logic [1:0] {
    BSC_MODE_NORMAL,
    BSC_MODE_SAMPLE,
    BSC_MODE_EXTEST
  } bsc_mode_type;

endpackage : bsc_pkg

// ===== bsc_chain.sv
// Boundary-scan chain for port pins and the reset pin, with its control registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Pull-ups are disabled while external-test or sample/preload is loaded.
// - Each pin cell merges control, output and input into two flops.
// - Captured input equals the pin level, without the port input register.
// - Normally pin output follows the port register, enable follows direction.
// - Pull-up is on only without global off, as input, with port bit one.
// - Capture records the real pad level, not an internal function signal.
// - Analog control signals are forced off during boundary-scan.
// - System clock is kept off the pin under external-test or sample/preload.
// - A clock on a pin is never captured into the chain.
// - Reset pin has an observe-only cell with no drive back.
// - Test interface enabled when disable bit clear and fuse programmed.
// - Disable bit changes only on two equal writes within four cycles.
// - Test-reset flag sets when the test reset register holds the core reset.
// - Test-reset flag clears on power-on reset or software writing zero.
// - Chain bit 0 is the first bit shifted in and out.
// - Chain follows pin order; flagged ports are scanned in reversed bit order.
// - Analog cells would take the top chain positions; none exist here.
// - Control sits in the first cell flop, data in the second.
// - Test access port pins have no chain cells.
// - Each pin's data cell sits at the odd position above its control cell.
// - Instruction register is four bits; all shift registers go LSB first.
// - External-test selects the chain and drives the update latches at once.
// - Sample/preload captures pins and updates latches without driving pins.
// - Reset instruction selects an unlatched bit holding the core in reset.
module bsc_chain #(
  parameter int unsigned NPINS    = 8,
  parameter int unsigned GROUP    = 4,
  parameter logic [1:0]  REV_MASK = 2'b10
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [7:0]       reg_rdata_o,
  input  wire logic             test_port_fuse_i,
  input  wire logic             clock_output_fuse_i,
  input  wire logic             tck_i,
  input  wire logic             tdi_i,
  input  wire logic             ir_capture_i,
  input  wire logic             ir_shift_i,
  input  wire logic             ir_update_i,
  input  wire logic             dr_capture_i,
  input  wire logic             dr_shift_i,
  input  wire logic             dr_update_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  input  wire logic [NPINS-1:0] pin_output_register_i,
  input  wire logic [NPINS-1:0] direction_register_i,
  input  wire logic [NPINS-1:0] pad_i,
  input  wire logic             reset_pad_n_i,
  output logic      [NPINS-1:0] pad_o,
  output logic      [NPINS-1:0] pad_oe_o,
  output logic      [NPINS-1:0] pullup_active_o,
  output logic                  clk_pin_en_o,
  output logic                  analog_ctrl_off_o,
  output logic                  core_reset_o,
  output logic                  iface_enable_o
);

  localparam int unsigned CHAIN_LEN = 2 * NPINS + 1;
  localparam int unsigned RST_POS   = 2 * NPINS;

  //////////////////////////////////////////////////////////////////////////////
  // Maps a cell pair index to its pin, reversing flagged groups.
  function automatic int unsigned pin_of(input int unsigned p);
    int unsigned grp;
    int unsigned idx;
    grp = p / GROUP;
    idx = p % GROUP;
    if (REV_MASK[grp])
    begin
      idx = GROUP - 1 - idx;
    end
    return grp * GROUP + idx;
  endfunction : pin_of

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers for link and pad inputs.
  logic [6:0]       lnk_s1_r;
  logic [6:0]       lnk_s2_r;
  logic             tck_d_r;
  logic [NPINS:0]   pad_s1_r;
  logic [NPINS:0]   pad_s2_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lnk_s1_r <= '0;
      lnk_s2_r <= '0;
      tck_d_r  <= 1'b0;
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end
    else
    begin
      lnk_s1_r <= {tck_i, tdi_i, ir_capture_i, ir_shift_i, ir_update_i, dr_capture_i,
                   dr_shift_i};
      lnk_s2_r <= lnk_s1_r;
      tck_d_r  <= lnk_s2_r[6];
      pad_s1_r <= {reset_pad_n_i, pad_i};
      pad_s2_r <= pad_s1_r;
    end
  end

  logic dru_s1_r;
  logic dru_s2_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dru_s1_r <= 1'b0;
      dru_s2_r <= 1'b0;
    end
    else
    begin
      dru_s1_r <= dr_update_i;
      dru_s2_r <= dru_s1_r;
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tdi_s;
  logic irc_s;
  logic irs_s;
  logic iru_s;
  logic drc_s;
  logic drs_s;

  assign tck_rise = lnk_s2_r[6] & ~tck_d_r;
  assign tck_fall = ~lnk_s2_r[6] & tck_d_r;
  assign tdi_s    = lnk_s2_r[5];
  assign irc_s    = lnk_s2_r[4];
  assign irs_s    = lnk_s2_r[3];
  assign iru_s    = lnk_s2_r[2];
  assign drc_s    = lnk_s2_r[1];
  assign drs_s    = lnk_s2_r[0];

  //////////////////////////////////////////////////////////////////////////////
  // Control register with timed interface-disable bit.
  logic [7:0] ctrl_r;
  logic       pend_val_r;
  logic [2:0] pend_cnt_r;
  logic       wr_ctrl;
  logic       wr_stat;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == bsc_pkg::ADDR_MCU_CONTROL);
  assign wr_stat = reg_wr_i && (reg_addr_i == bsc_pkg::ADDR_MCU_RESET_STATUS);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_r     <= bsc_pkg::RESET_VAL_8;
      pend_val_r <= 1'b0;
      pend_cnt_r <= '0;
    end
    else if (wr_ctrl)
    begin
      ctrl_r[bsc_pkg::BIT_PULLUP_OFF] <= reg_wdata_i[bsc_pkg::BIT_PULLUP_OFF];
      ctrl_r[1:0]                     <= reg_wdata_i[1:0];
      if ((pend_cnt_r != '0) && (reg_wdata_i[bsc_pkg::BIT_IFACE_DISABLE] == pend_val_r))
      begin
        ctrl_r[bsc_pkg::BIT_IFACE_DISABLE] <= pend_val_r;
        pend_cnt_r                         <= '0;
      end
      else
      begin
        pend_val_r <= reg_wdata_i[bsc_pkg::BIT_IFACE_DISABLE];
        pend_cnt_r <= bsc_pkg::DISABLE_WINDOW - 3'h1;
      end
    end
    else if (pend_cnt_r != '0)
    begin
      pend_cnt_r <= pend_cnt_r - 3'h1;
    end
  end

  logic iface_en;
  assign iface_en = test_port_fuse_i & ~ctrl_r[bsc_pkg::BIT_IFACE_DISABLE];

  //////////////////////////////////////////////////////////////////////////////
  // Instruction register, shifted LSB first.
  logic [3:0] ir_shift_r;
  logic [3:0] ir_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ir_shift_r <= bsc_pkg::IR_CAPTURE_VAL;
      ir_r       <= bsc_pkg::OP_IDCODE;
    end
    else if (!iface_en)
    begin
      ir_r <= bsc_pkg::OP_IDCODE;
    end
    else if (tck_rise)
    begin
      if (irc_s)
      begin
        ir_shift_r <= bsc_pkg::IR_CAPTURE_VAL;
      end
      else if (irs_s)
      begin
        ir_shift_r <= {tdi_s, ir_shift_r[3:1]};
      end
      else if (iru_s)
      begin
        ir_r <= ir_shift_r;
      end
    end
  end

  bsc_pkg::bsc_mode_type mode;
  always_comb
  begin
    if (ir_r == bsc_pkg::OP_EXTEST)
    begin
      mode = bsc_pkg::BSC_MODE_EXTEST;
    end
    else if (ir_r == bsc_pkg::OP_SAMPLE)
    begin
      mode = bsc_pkg::BSC_MODE_SAMPLE;
    end
    else
    begin
      mode = bsc_pkg::BSC_MODE_NORMAL;
    end
  end

  logic scan_mode;
  logic chain_sel;
  logic rst_sel;
  assign scan_mode = (mode != bsc_pkg::BSC_MODE_NORMAL);
  assign chain_sel = scan_mode;
  assign rst_sel   = (ir_r == bsc_pkg::OP_TEST_RESET_INSTR);

  //////////////////////////////////////////////////////////////////////////////
  // Boundary chain, test reset bit and bypass bit.
  logic [CHAIN_LEN-1:0] chain_r;
  logic [NPINS-1:0]     upd_data_r;
  logic [NPINS-1:0]     upd_ctrl_r;
  logic                 rst_bit_r;
  logic                 byp_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chain_r <= '0;
      byp_r   <= 1'b0;
    end
    else if (tck_rise && drc_s)
    begin
      byp_r <= 1'b0;
      if (chain_sel)
      begin
        for (int unsigned p = 0; p < NPINS; p++)
        begin
          chain_r[2*p+1] <= pad_s2_r[pin_of(p)];
          chain_r[2*p]   <= pad_oe_o[pin_of(p)];
        end
        chain_r[RST_POS] <= pad_s2_r[NPINS];
      end
    end
    else if (tck_rise && drs_s)
    begin
      byp_r <= tdi_s;
      if (chain_sel)
      begin
        chain_r <= {tdi_s, chain_r[CHAIN_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      upd_data_r <= '0;
      upd_ctrl_r <= '0;
    end
    else if (dru_s2_r && tck_rise && chain_sel)
    begin
      for (int unsigned p = 0; p < NPINS; p++)
      begin
        upd_data_r[pin_of(p)] <= chain_r[2*p+1];
        upd_ctrl_r[pin_of(p)] <= chain_r[2*p];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rst_bit_r <= 1'b0;
    end
    else if (tck_rise && drs_s && rst_sel)
    begin
      rst_bit_r <= tdi_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test data output, changed on the falling test clock edge.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_o <= iface_en & (irs_s | drs_s);
      if (irs_s)
      begin
        tdo_o <= ir_shift_r[0];
      end
      else if (chain_sel)
      begin
        tdo_o <= chain_r[0];
      end
      else if (rst_sel)
      begin
        tdo_o <= rst_bit_r;
      end
      else
      begin
        tdo_o <= byp_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive, pull-ups, clock gating and core reset.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pad_o             <= '0;
      pad_oe_o          <= '0;
      pullup_active_o   <= '0;
      clk_pin_en_o      <= 1'b0;
      analog_ctrl_off_o <= 1'b0;
      core_reset_o      <= 1'b0;
      iface_enable_o    <= 1'b0;
    end
    else
    begin
      if (mode == bsc_pkg::BSC_MODE_EXTEST)
      begin
        pad_o    <= upd_data_r;
        pad_oe_o <= upd_ctrl_r;
      end
      else
      begin
        pad_o    <= pin_output_register_i;
        pad_oe_o <= direction_register_i;
      end
      pullup_active_o <= (scan_mode || ctrl_r[bsc_pkg::BIT_PULLUP_OFF]) ? '0
                       : (~direction_register_i & pin_output_register_i);
      clk_pin_en_o      <= clock_output_fuse_i & ~scan_mode;
      analog_ctrl_off_o <= scan_mode;
      core_reset_o      <= rst_sel & rst_bit_r;
      iface_enable_o    <= iface_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset status flag and register read port.
  logic scan_reset_flag_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      scan_reset_flag_r <= 1'b0;
    end
    else if (core_reset_o)
    begin
      scan_reset_flag_r <= 1'b1;
    end
    else if (wr_stat && !reg_wdata_i[bsc_pkg::BIT_SCAN_RESET_FLAG])
    begin
      scan_reset_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= bsc_pkg::RESET_VAL_8;
    end
    else if (reg_rd_i && (reg_addr_i == bsc_pkg::ADDR_MCU_CONTROL))
    begin
      reg_rdata_o <= ctrl_r;
    end
    else if (reg_rd_i && (reg_addr_i == bsc_pkg::ADDR_MCU_RESET_STATUS))
    begin
      reg_rdata_o <= {3'h0, scan_reset_flag_r, 4'h0};
    end
    else
    begin
      reg_rdata_o <= bsc_pkg::RESET_VAL_8;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_pullup_scan: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(scan_mode) |-> (pullup_active_o == '0))
    else $error("Pull-up active during boundary-scan.");

  chk_pullup_expr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) && !$past(scan_mode) && !$past(ctrl_r[bsc_pkg::BIT_PULLUP_OFF]) |->
      pullup_active_o == ($past(pin_output_register_i) & ~$past(direction_register_i)))
    else $error("Pull-up enable wrong.");

  chk_clock_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(scan_mode) |-> !clk_pin_en_o)
    else $error("Clock driven on pin during scan.");

  chk_extest_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(mode == bsc_pkg::BSC_MODE_EXTEST) |->
      (pad_oe_o == $past(upd_ctrl_r)) && (pad_o == $past(upd_data_r)))
    else $error("Pins not driven from update latches.");

  chk_normal_path: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) && $past(mode == bsc_pkg::BSC_MODE_NORMAL) |->
      (pad_oe_o == $past(direction_register_i)))
    else $error("Output enable not following direction.");

  chk_single_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_ctrl && (pend_cnt_r == '0) |=> $stable(ctrl_r[bsc_pkg::BIT_IFACE_DISABLE]))
    else $error("Disable bit changed on a single write.");

  chk_iface_enable: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ctrl_r[bsc_pkg::BIT_IFACE_DISABLE] |=> !iface_enable_o)
    else $error("Interface enabled while disabled.");

  chk_flag_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    core_reset_o |=> scan_reset_flag_r)
    else $error("Test-reset flag not set.");

  chk_reset_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rst_sel && rst_bit_r ##1 rst_sel && rst_bit_r |-> core_reset_o)
    else $error("Core not held in reset.");

  chk_analog_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    scan_mode ##1 scan_mode |-> analog_ctrl_off_o)
    else $error("Analog controls not forced off.");

endmodule : bsc_chain

`default_nettype wire

// ===== bsc_tester.sv
// Behavioural boundary-scan tester that drives the test port.
`timescale 1ns/1ps
`default_nettype none
module bsc_tester (
  output logic      tck_o,
  output logic      tdi_o,
  output logic      ir_cap_o,
  output logic      ir_sh_o,
  output logic      ir_up_o,
  output logic      dr_cap_o,
  output logic      dr_sh_o,
  output logic      dr_up_o,
  input  wire logic tdo_i
);
  initial
  begin
    {tck_o, tdi_o, ir_cap_o, ir_sh_o, ir_up_o, dr_cap_o, dr_sh_o, dr_up_o} = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // One test clock period of 160 ns, entered 40 ns after a rise, when the state levels change.
  // Levels thus follow the controller state, which moves on each rising test clock edge.
  task automatic tick(output logic s);
    #40;
    tck_o = 1'b0;
    #60;
    s     = tdo_i;
    #20;
    tck_o = 1'b1;
    #40;
  endtask : tick

  // Capture, shift n bits, then update; the test clock stands still outside frames.
  task automatic scan(input logic ir, input int n, input logic [16:0] din,
                      output logic [16:0] dout);
    logic s;
    dout     = '0;
    ir_cap_o = ir;
    dr_cap_o = ~ir;
    tick(s);
    ir_cap_o = 1'b0;
    dr_cap_o = 1'b0;
    ir_sh_o  = ir;
    dr_sh_o  = ~ir;
    for (int i = 0; i < n; i++)
    begin
      tdi_o = din[i];
      tick(dout[i]);
    end
    ir_sh_o = 1'b0;
    dr_sh_o = 1'b0;
    tdi_o   = ~tdi_o;
    ir_up_o = ir;
    dr_up_o = ~ir;
    tick(s);
    ir_up_o = 1'b0;
    dr_up_o = 1'b0;
    #40;
    tck_o   = 1'b0;
  endtask : scan
endmodule : bsc_tester
`default_nettype wire

// ===== bsc_chain_test.sv
// Self-checking testbench for the boundary-scan pin chain.
`timescale 1ns/1ps
`default_nettype none
module bsc_chain_test;
  localparam int unsigned NP = 8;
  localparam logic [1:0]  RM = 2'b10;
  logic          clk, rst, wr, rd, rn, tck, tdi, irc, irs, iru, drc, drs, dru, tdo, tdo_oe;
  logic          clk_en, an_off, core_rst, if_en, fuse, ck_fuse;
  logic [7:0]    addr, wdata, rdata, d;
  logic [NP-1:0] por, ddr, ext, pad, pad_d, pad_en, pu;
  logic [16:0]   v, ex, so;
  logic [15:0]   dr;
  int            seed = 35;
  int            n_fail, num_checks;

  // Board wire: the pad shows the chip's drive when enabled, else the outside level.
  assign pad = (pad_en & pad_d) | (~pad_en & ext);

  bsc_chain #(.NPINS(NP), .GROUP(4), .REV_MASK(RM)) bsc_chain_inst (
    .ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .test_port_fuse_i(fuse), .clock_output_fuse_i(ck_fuse),
    .tck_i(tck), .tdi_i(tdi), .ir_capture_i(irc), .ir_shift_i(irs), .ir_update_i(iru),
    .dr_capture_i(drc), .dr_shift_i(drs), .dr_update_i(dru), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .pin_output_register_i(por), .direction_register_i(ddr), .pad_i(pad), .reset_pad_n_i(rn),
    .pad_o(pad_d), .pad_oe_o(pad_en), .pullup_active_o(pu), .clk_pin_en_o(clk_en),
    .analog_ctrl_off_o(an_off), .core_reset_o(core_rst), .iface_enable_o(if_en));

  bsc_tester bsc_tester_inst (.tck_o(tck), .tdi_o(tdi), .ir_cap_o(irc), .ir_sh_o(irs),
    .ir_up_o(iru), .dr_cap_o(drc), .dr_sh_o(drs), .dr_up_o(dru), .tdo_i(tdo));

  ////////////////////////////////////////////////////////////
  // Pin scanned by pair p; flagged groups of four run in reversed order.
  function automatic int pin_of(int p);
    return RM[p / 4] ? (p / 4) * 4 + 3 - p % 4 : p;
  endfunction : pin_of

  // Chain image: control at 2p, data at 2p+1, reset pin level on top.
  function automatic logic [16:0] cap_of(logic [NP-1:0] pd, logic [NP-1:0] oe, logic r);
    logic [16:0] c;
    for (int p = 0; p < NP; p++)
    begin
      c[2*p]   = oe[pin_of(p)];
      c[2*p+1] = pd[pin_of(p)];
    end
    c[16] = r;
    return c;
  endfunction : cap_of

  // Pad drive that a chain image gives: data in the upper byte, enable in the lower.
  function automatic logic [15:0] drv_of(logic [16:0] c);
    logic [15:0] r;
    for (int p = 0; p < NP; p++)
    begin
      r[pin_of(p)]      = c[2*p];
      r[NP + pin_of(p)] = c[2*p+1];
    end
    return r;
  endfunction : drv_of

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt, input int gap);
    idle(gap + 1);
    addr  <= a;
    wdata <= dt;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dt);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    dt = rdata;
  endtask : rd_reg

  task automatic new_pins();
    @(posedge clk);
    por <= NP'($random(seed));
    ddr <= NP'($random(seed));
    ext <= NP'($random(seed));
    rn  <= 1'($random(seed));
    idle(4);
  endtask : new_pins

  task automatic sc(input logic ir, input int n, input logic [16:0] din);
    bsc_tester_inst.scan(ir, n, din, so);
    idle(8);
  endtask : sc

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The tests need about 32 us; a hang is cut short well after that.
  initial
  begin
    #200us;
    n_fail++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    {addr, wdata} = 16'h0000;
    {wr, rd, rn, fuse, ck_fuse} = 5'h07;
    {por, ddr, ext} = 24'h00_0000;
    n_fail = 0;
    num_checks = 0;
    idle(10);
    rst <= 1'b0;
    idle(2);
    rd_reg(8'h35, d); chk("ctrl", d, 8'h00);
    rd_reg(8'h34, d); chk("status", d, 8'h00);
    rd_reg(8'h10, d); chk("unmapped", d, 8'h00);
    chk("iface_en", if_en, 1'b1);
    chk("tdo_oe", tdo_oe, 1'b0);
    wr_reg(8'h35, 8'hFF, 0);
    rd_reg(8'h35, d); chk("ctrl_bits", d, 8'h13);
    $display("Test reset and registers done");
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'h35, k ? 8'h00 : 8'h10, 0);
      repeat (10)
      begin
        new_pins();
        chk("pad", pad_d, por);
        chk("pad_oe", pad_en, ddr);
        chk("pullup", pu, ~ddr & por & {NP{k == 1}});
        chk("clk_pin", clk_en, 1'b1);
        chk("analog_off", an_off, 1'b0);
      end
    end
    fuse    <= 1'b0;
    ck_fuse <= 1'b0;
    idle(2);
    chk("fuse_off", if_en, 1'b0);
    chk("clk_fuse", clk_en, 1'b0);
    fuse    <= 1'b1;
    ck_fuse <= 1'b1;
    $display("Test normal pins done");
    wr_reg(8'h35, 8'h80, 0);
    wr_reg(8'h35, 8'h80, 2);
    rd_reg(8'h35, d); chk("late_write", d, 8'h00);
    idle(4);
    wr_reg(8'h35, 8'h80, 0);
    wr_reg(8'h35, 8'h80, 1);
    rd_reg(8'h35, d); chk("timed_write", d, 8'h80);
    idle(2); chk("iface_off", if_en, 1'b0);
    sc(1'b1, 4, 17'h0_0002);
    chk("off_ir", an_off, 1'b0);
    wr_reg(8'h35, 8'h00, 0);
    wr_reg(8'h35, 8'h00, 0);
    idle(2); chk("iface_on", if_en, 1'b1);
    $display("Test interface disable done");
    repeat (3)
    begin
      new_pins();
      sc(1'b1, 4, 17'h0_0002);
      chk("ir_capture", so[3:0], 4'h1);
      chk("pullup_s", pu, 8'h00);
      chk("clk_pin_s", clk_en, 1'b0);
      chk("analog_s", an_off, 1'b1);
      v  = 17'($random(seed));
      ex = cap_of((ddr & por) | (~ddr & ext), ddr, rn);
      sc(1'b0, 17, v);
      chk("capture_s", so, ex);
      chk("pad_s", pad_d, por);
      chk("pad_oe_s", pad_en, ddr);
      sc(1'b1, 4, 17'h0_0000);
      dr = drv_of(v);
      chk("preload_x", {pad_d, pad_en}, dr);
      chk("pullup_x", pu, 8'h00);
      chk("clk_pin_x", clk_en, 1'b0);
      ex = cap_of((dr[7:0] & dr[15:8]) | (~dr[7:0] & ext), dr[7:0], rn);
      v  = 17'($random(seed));
      sc(1'b0, 17, v);
      chk("capture_x", so, ex);
      chk("update_x", {pad_d, pad_en}, drv_of(v));
    end
    $display("Test sample and external test done");
    sc(1'b1, 4, 17'h0_000C);
    sc(1'b0, 1, 17'h0_0001);
    chk("core_reset", core_rst, 1'b1);
    rd_reg(8'h34, d); chk("flag_set", d, 8'h10);
    sc(1'b0, 1, 17'h0_0000);
    chk("core_free", core_rst, 1'b0);
    wr_reg(8'h34, 8'hFF, 0);
    rd_reg(8'h34, d); chk("flag_keep", d, 8'h10);
    wr_reg(8'h34, 8'h00, 0);
    rd_reg(8'h34, d); chk("flag_clear", d, 8'h00);
    sc(1'b0, 1, 17'h0_0001);
    sc(1'b0, 1, 17'h0_0000);
    @(posedge clk);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(2);
    rd_reg(8'h34, d); chk("flag_por", d, 8'h00);
    chk("pad_rst", pad_d, por);
    $display("Test reset instruction done");
    finish_test();
  end
endmodule : bsc_chain_test
`default_nettype wire
